// [hdl/lat_table_host.sv]
// Overview of operation
// - First byte is the table parameter identifier
// - Second byte counts the following parameter bytes
// - Header starts with ASCII F then C
// - Header lists plain then fast read codes
// - Then dual-output then quad-output read codes
// - Ends with dual I/O then quad I/O codes
// - Row two: up to 50 MHz, code 11b
// - Row two simple reads need no extra cycles
// - Dual I/O: four mode, zero latency cycles
// - Row two quad I/O: two mode, one latency
// - Row three: up to 80 MHz, code 00b
// - All ones means unsupported; never issue it
// - Row three fast and output reads: eight latency; plain read all ones
// - Row three quad I/O: two mode, two latency
//
// Host end: walks the table byte by byte and picks the row for its clock.
// Assumes the device answers each req with ack one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lat_table_host
  import lat_table_pkg::*;
#(
  parameter logic [7:0] SCK_MHZ = 8'h32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [3:0] op_sel,
  // Link
  lat_query_if.host_end link,
  // Results
  output logic done_ff,
  output logic table_ok_ff,
  output logic [1:0] lat_code_ff,
  output logic [7:0] mode_cyc_ff,
  output logic [7:0] lat_cyc_ff,
  output logic op_ok_ff
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ASK = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } state_t;

  state_t state_ff;
  logic [6:0] addr_ff;
  logic req_ff;
  logic [6:0] row_base_ff;
  logic row_found_ff;
  logic [3:0] op_ff;
  logic [6:0] end_ff;

  // Offset of a byte within the row being examined
  function automatic logic [6:0] rel_ofs(input logic [6:0] a, input logic [6:0] b);
    rel_ofs = a - b;
  endfunction : rel_ofs

  // Mode byte of the chosen instruction sits after freq and code
  function automatic logic [6:0] mode_ofs(input logic [3:0] op);
    mode_ofs = {2'b00, op, 1'b0} + REL_MODE;
  endfunction : mode_ofs

  logic [6:0] rel;
  logic in_row;
  assign rel = rel_ofs(addr_ff, row_base_ff);
  assign in_row = (addr_ff >= OFS_ROW2) && (rel < ROW_STEP);
  // Length byte plus its own offset is the last byte of this parameter
  logic [7:0] len_end;
  assign len_end = link.data + {1'b0, OFS_LEN};

  // ==========================================
  // Sequencer: reads offsets upward, one byte at a time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      addr_ff <= OFS_ID;
      req_ff <= 1'b0;
      done_ff <= 1'b0;
      op_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start) begin
            addr_ff <= OFS_ID;
            // Codes beyond the listed instructions fall back to the plain read
            op_ff <= (op_sel[3:1] < NUM_OPS) ? {1'b0, op_sel[3:1]} : 4'h0;
            done_ff <= 1'b0;
            req_ff <= 1'b1;
            state_ff <= ST_ASK;
          end
        end
        ST_ASK: begin
          // Request stands one cycle; the answer comes on the next edge
          req_ff <= 1'b0;
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (link.ack) begin
            if (addr_ff >= end_ff) begin
              done_ff <= 1'b1;
              state_ff <= ST_DONE;
            end else begin
              addr_ff <= addr_ff + 7'h01;
              req_ff <= 1'b1;
              state_ff <= ST_ASK;
            end
          end
        end
        ST_DONE: begin
          if (start) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Walk limit: the length byte marks the true end, but only rows two
  // and three are decoded here, so the walk never goes past them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      end_ff <= OFS_LAST;
    end else if (state_ff == ST_IDLE && start) begin
      end_ff <= OFS_LAST;
    end else if (state_ff == ST_WAIT && link.ack && addr_ff == OFS_LEN) begin
      end_ff <= (len_end < {1'b0, OFS_LAST}) ? len_end[6:0] : OFS_LAST;
    end
  end

  // ==========================================
  // Header check: identifier, row length and both column characters
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      table_ok_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && start) begin
      table_ok_ff <= 1'b0;
    end else if (state_ff == ST_WAIT && link.ack) begin
      if (addr_ff == OFS_ID) begin
        table_ok_ff <= (link.data == PARAM_ID);
      end
      // Rows are stepped by a fixed length, so another length is unusable
      if (addr_ff == OFS_ROW_LEN) begin
        table_ok_ff <= table_ok_ff && (link.data == ROW_LEN);
      end
      if (addr_ff == OFS_HDR) begin
        table_ok_ff <= table_ok_ff && (link.data == HDR_FREQ_CHAR);
      end
      if (addr_ff == OFS_HDR_CODE) begin
        table_ok_ff <= table_ok_ff && (link.data == HDR_CODE_CHAR);
      end
    end
  end

  // ==========================================
  // Row selection: rows rise in frequency, so the first one whose
  // limit covers our clock is the lowest usable one
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      row_base_ff <= OFS_ROW2;
      row_found_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && start) begin
      row_base_ff <= OFS_ROW2;
      row_found_ff <= 1'b0;
    end else if (state_ff == ST_WAIT && link.ack && in_row && !row_found_ff) begin
      if (rel == REL_FREQ && link.data < SCK_MHZ) begin
        row_base_ff <= row_base_ff + ROW_STEP;
      end
      if (rel == ROW_STEP - 7'h01) begin
        row_found_ff <= 1'b1;
      end
    end
  end

  // ==========================================
  // Result capture from the chosen row; a mode byte always precedes
  // its latency byte, so both are known when op_ok is decided
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lat_code_ff <= 2'b00;
      mode_cyc_ff <= CYC_NOT_SUPP;
      lat_cyc_ff <= CYC_NOT_SUPP;
      op_ok_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && start) begin
      mode_cyc_ff <= CYC_NOT_SUPP;
      lat_cyc_ff <= CYC_NOT_SUPP;
      op_ok_ff <= 1'b0;
    end else if (state_ff == ST_WAIT && link.ack && in_row && !row_found_ff) begin
      if (rel == REL_CODE) begin
        lat_code_ff <= link.data[1:0];
      end else if (rel == mode_ofs(op_ff)) begin
        mode_cyc_ff <= link.data;
      end else if (rel == mode_ofs(op_ff) + 7'h01) begin
        lat_cyc_ff <= link.data;
        // All ones forbids this instruction at this rate
        op_ok_ff <= (mode_cyc_ff != CYC_NOT_SUPP) && (link.data != CYC_NOT_SUPP);
      end
    end
  end

  assign link.req = req_ff;
  assign link.addr = addr_ff;
endmodule : lat_table_host
`default_nettype wire

// [common/lat_table_pkg.sv]
// Constants for the read latency code table parameter and its query link.
// Assumes one clock domain; offsets are relative to the parameter's first byte.
package lat_table_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  // ==========================================
  // Parameter header
  localparam logic [7:0] PARAM_ID = 8'h90;
  localparam logic [7:0] PARAM_LEN = 8'h56;
  localparam logic [7:0] NUM_ROWS = 8'h06;
  localparam logic [7:0] ROW_LEN = 8'h0e;
  localparam logic [7:0] HDR_FREQ_CHAR = 8'h46;
  localparam logic [7:0] HDR_CODE_CHAR = 8'h43;
  // ==========================================
  // Instruction codes of the header row
  localparam logic [7:0] OP_READ3 = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST3 = 8'h0b;
  localparam logic [7:0] OP_FAST4 = 8'h0c;
  localparam logic [7:0] OP_DOUT3 = 8'h3b;
  localparam logic [7:0] OP_DOUT4 = 8'h3c;
  localparam logic [7:0] OP_QOUT3 = 8'h6b;
  localparam logic [7:0] OP_QOUT4 = 8'h6c;
  localparam logic [7:0] OP_DIO3 = 8'hbb;
  localparam logic [7:0] OP_DIO4 = 8'hbc;
  localparam logic [7:0] OP_QIO3 = 8'heb;
  localparam logic [7:0] OP_QIO4 = 8'hec;
  // ==========================================
  // Rows
  localparam logic [7:0] ROW2_FREQ = 8'h32;
  localparam logic [7:0] ROW2_CODE = 8'h03;
  localparam logic [7:0] ROW3_FREQ = 8'h50;
  localparam logic [7:0] ROW3_CODE = 8'h00;
  localparam logic [7:0] CYC_ZERO = 8'h00;
  localparam logic [7:0] CYC_NOT_SUPP = 8'hff;
  localparam logic [7:0] CYC_DIO_MODE = 8'h04;
  localparam logic [7:0] CYC_QIO_MODE = 8'h02;
  localparam logic [7:0] ROW2_QIO_LAT = 8'h01;
  localparam logic [7:0] ROW3_QIO_LAT = 8'h02;
  localparam logic [7:0] ROW3_STD_LAT = 8'h08;
  // ==========================================
  // Offsets
  localparam logic [6:0] OFS_ID = 7'h00;
  localparam logic [6:0] OFS_LEN = 7'h01;
  localparam logic [6:0] OFS_HDR = 7'h04;
  localparam logic [6:0] OFS_ROW2 = 7'h12;
  localparam logic [6:0] OFS_ROW3 = 7'h20;
  localparam logic [6:0] OFS_LAST = 7'h2d;
  localparam logic [6:0] ROW_STEP = 7'h0e;
  localparam logic [6:0] OFS_ROW_LEN = 7'h03;
  localparam logic [6:0] OFS_HDR_CODE = 7'h05;
  // Fields within a row
  localparam logic [6:0] REL_FREQ = 7'h00;
  localparam logic [6:0] REL_CODE = 7'h01;
  localparam logic [6:0] REL_MODE = 7'h02;
  // Entries within a row after freq and code
  localparam int unsigned ENTRY_CNT = 12;
  // Host selection
  localparam logic [7:0] NO_ROW_CODE = 8'hff;
  localparam logic [2:0] NUM_OPS = 3'h6;
endpackage : lat_table_pkg

// [common/lat_query_if.sv]
// Byte query link between the table holder and the host controller.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface lat_query_if;
  logic req;
  logic [6:0] addr;
  logic ack;
  logic [7:0] data;
  modport table_end (input req, input addr, output ack, output data);
  modport host_end (output req, output addr, input ack, input data);
endinterface : lat_query_if
`default_nettype wire

// [hdl/lat_rom.sv]
// Combinational byte lookup of the latency code table parameter.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module lat_rom
  import lat_table_pkg::*;
(
  // Lookup
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  always_comb begin
    unique case (addr)
      7'h00: data = PARAM_ID;
      7'h01: data = PARAM_LEN;
      7'h02: data = NUM_ROWS;
      7'h03: data = ROW_LEN;
      7'h04: data = HDR_FREQ_CHAR;
      7'h05: data = HDR_CODE_CHAR;
      7'h06: data = OP_READ3;
      7'h07: data = OP_READ4;
      7'h08: data = OP_FAST3;
      7'h09: data = OP_FAST4;
      7'h0a: data = OP_DOUT3;
      7'h0b: data = OP_DOUT4;
      7'h0c: data = OP_QOUT3;
      7'h0d: data = OP_QOUT4;
      7'h0e: data = OP_DIO3;
      7'h0f: data = OP_DIO4;
      7'h10: data = OP_QIO3;
      7'h11: data = OP_QIO4;
      7'h12: data = ROW2_FREQ;
      7'h13: data = ROW2_CODE;
      7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b: data = CYC_ZERO;
      7'h1c: data = CYC_DIO_MODE;
      7'h1d: data = CYC_ZERO;
      7'h1e: data = CYC_QIO_MODE;
      7'h1f: data = ROW2_QIO_LAT;
      7'h20: data = ROW3_FREQ;
      7'h21: data = ROW3_CODE;
      7'h22, 7'h23: data = CYC_NOT_SUPP;
      7'h24, 7'h26, 7'h28: data = CYC_ZERO;
      7'h25, 7'h27, 7'h29: data = ROW3_STD_LAT;
      7'h2a: data = CYC_DIO_MODE;
      7'h2b: data = CYC_ZERO;
      7'h2c: data = CYC_QIO_MODE;
      7'h2d: data = ROW3_QIO_LAT;
      // Later rows lie outside this block and read as zero
      default: data = CYC_ZERO;
    endcase
  end
endmodule : lat_rom
`default_nettype wire

// [hdl/lat_table_dev.sv]
// Device end: answers each byte query from the latency code table.
// Assumes the host holds req one cycle per byte and waits for ack.
`timescale 1ns/1ps
`default_nettype none
module lat_table_dev
  import lat_table_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link
  lat_query_if.table_end link,
  // Status
  output logic busy_ff
);
  logic [7:0] rom_data;
  logic [7:0] data_ff;
  logic ack_ff;

  lat_rom u_rom (
    .addr(link.addr),
    .data(rom_data)
  );

  // ==========================================
  // One byte per query, one cycle after it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_ff <= CYC_ZERO;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= link.req;
      if (link.req) begin
        data_ff <= rom_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= link.req;
    end
  end

  assign link.ack = ack_ff;
  assign link.data = data_ff;
endmodule : lat_table_dev
`default_nettype wire

// [tb/lat_query_assertions.sv]
// Checker for the byte query link between host end and table end.
// Assumes one clock; takes the link signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module lat_query_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link
  input wire logic req,
  input wire logic [6:0] addr,
  input wire logic ack,
  input wire logic [7:0] data
);
  // ==========================================
  // Helpers
  logic [6:0] last_addr_ff;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk) begin
    if (!resetn) last_addr_ff <= 7'h00;
    else if (req) last_addr_ff <= addr;
  end
  sequence s_query;
    req ##1 ack;
  endsequence
  // One byte answer for a given offset
  property p_byte(logic [6:0] ofs, logic [7:0] val);
    req && addr == ofs |=> ack && data == val;
  endproperty
  // ==========================================
  // Checks
  a_ack_one_later: assert property (req |=> ack)
    else $error("ack missing after req");
  a_ack_single: assert property (s_query |=> !ack)
    else $error("ack longer than one cycle");
  a_data_hold: assert property (!ack |-> $stable(data))
    else $error("data moved without ack");
  a_addr_ascend: assert property (req && addr != 7'h00 |-> addr == last_addr_ff + 7'h01)
    else $error("query offsets not ascending");
  a_id_byte: assert property (p_byte(7'h00, 8'h90))
    else $error("identifier byte wrong");
  a_len_byte: assert property (p_byte(7'h01, 8'h56))
    else $error("length byte wrong");
  a_hdr_char: assert property (p_byte(7'h05, 8'h43))
    else $error("code column char wrong");
  a_row2_code: assert property (p_byte(7'h13, 8'h03))
    else $error("row two code wrong");
  a_row2_qio: assert property (p_byte(7'h1f, 8'h01))
    else $error("row two quad io latency wrong");
  a_row3_code: assert property (p_byte(7'h21, 8'h00))
    else $error("row three code wrong");
  a_row3_unsupp: assert property (p_byte(7'h22, 8'hff))
    else $error("row three read not marked unsupported");
  a_row3_qio: assert property (p_byte(7'h2d, 8'h02))
    else $error("row three quad io latency wrong");
endmodule : lat_query_assertions
`default_nettype wire

// [tb/read_latency_code_table_rom_tb.sv]
// Testbench: two host ends against table ends, plus a third table end read directly.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module read_latency_code_table_rom_tb;
  // ==========================================
  // Expected table and host results
  localparam logic [7:0] TBL [46] = '{8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43, 8'h03, 8'h13, 8'h0b, 8'h0c,
    8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01, 8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'h02};
  localparam logic [7:0] EXP_MODE [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] EXP_LAT [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  // Row three forbids the plain read, so its bytes stay all ones and op_ok drops
  localparam logic [7:0] EXP3_MODE [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'hff, 8'hff};
  localparam logic [7:0] EXP3_LAT [8] = '{8'hff, 8'h08, 8'h08, 8'h08, 8'h00, 8'h02, 8'hff, 8'hff};
  localparam logic [7:0] EXP3_OK [8] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h02};
  logic done_c, table_ok_c, op_ok_c, busy_b;
  logic [1:0] lat_code_c;
  logic [7:0] mode_cyc_c, lat_cyc_c;
  logic mclk, resetn, start, done_ff, table_ok_ff, op_ok_ff;
  logic [3:0] op_sel;
  logic [1:0] lat_code_ff;
  logic [7:0] mode_cyc_ff, lat_cyc_ff;
  int fails = 0;
  int n_tests = 0;
  lat_query_if link_a ();
  lat_query_if link_b ();
  lat_query_if link_c ();
  lat_table_dev i_lat_table_dev (.mclk(mclk), .resetn(resetn), .link(link_a), .busy_ff());
  lat_table_dev i_lat_table_dev_b (.mclk(mclk), .resetn(resetn), .link(link_b), .busy_ff(busy_b));
  lat_table_dev i_lat_table_dev_c (.mclk(mclk), .resetn(resetn), .link(link_c), .busy_ff());
  // Clock of 80 sits exactly on the row three limit
  lat_table_host #(.SCK_MHZ(8'h50)) i_lat_table_host_c (.mclk(mclk), .resetn(resetn), .start(start),
    .op_sel(op_sel), .link(link_c), .done_ff(done_c), .table_ok_ff(table_ok_c), .lat_code_ff(lat_code_c),
    .mode_cyc_ff(mode_cyc_c), .lat_cyc_ff(lat_cyc_c), .op_ok_ff(op_ok_c));
  // Clock of 50 sits exactly on the row two limit, so row three must not win
  lat_table_host #(.SCK_MHZ(8'h32)) i_lat_table_host (.mclk(mclk), .resetn(resetn), .start(start),
    .op_sel(op_sel), .link(link_a), .done_ff(done_ff), .table_ok_ff(table_ok_ff), .lat_code_ff(lat_code_ff),
    .mode_cyc_ff(mode_cyc_ff), .lat_cyc_ff(lat_cyc_ff), .op_ok_ff(op_ok_ff));
  lat_query_assertions i_lat_query_assertions (.mclk(mclk), .resetn(resetn), .req(link_a.req),
    .addr(link_a.addr), .ack(link_a.ack), .data(link_a.data));
  // ==========================================
  // Tasks
  task stop_test;
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Offset held until ack, so a slow answer still reads the right byte
  task rd_byte(input logic [6:0] a, output logic [7:0] d);
    int n;
    @(posedge mclk);
    #1 link_b.req = 1'b1;
    link_b.addr = a;
    @(posedge mclk);
    #1 link_b.req = 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (link_b.ack !== 1'b1 && n < 8);
    if (n >= 8) fails++;
    d = link_b.data;
    chk({7'h00, busy_b}, 8'h01);
  endtask : rd_byte
  task pulse_start;
    @(posedge mclk);
    #1 start = 1'b1;
    @(posedge mclk);
    #1 start = 1'b0;
  endtask : pulse_start
  task run_host(input logic [3:0] sel);
    int n;
    if (done_ff === 1'b1) pulse_start();
    op_sel = sel;
    pulse_start();
    n = 0;
    while ((done_ff !== 1'b1 || done_c !== 1'b1) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400) fails++;
    #1;
  endtask : run_host
  // ==========================================
  // Stimulus
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    int i;
    logic [7:0] d;
    resetn = 1'b0;
    start = 1'b0;
    op_sel = 4'h0;
    link_b.req = 1'b0;
    link_b.addr = 7'h00;
    repeat (5) @(posedge mclk);
    #1 resetn = 1'b1;
    for (i = 0; i < 18; i++) begin
      rd_byte(i[6:0], d);
      chk(d, TBL[i]);
    end
    for (i = 18; i < 46; i++) begin
      rd_byte(i[6:0], d);
      chk(d, TBL[i]);
    end
    rd_byte(7'h2e, d);
    chk(d, 8'h00);
    rd_byte(7'h7f, d);
    chk(d, 8'h00);
    // Second reset in mid run
    @(posedge mclk);
    #1 resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    chk(mode_cyc_ff, 8'hff);
    chk({7'h00, done_ff}, 8'h00);
    chk({6'h00, table_ok_ff, op_ok_ff}, 8'h00);
    // Every instruction, width bit set from bit 0 of i; 6 and 7 fall back to plain read
    for (i = 0; i < 8; i++) begin
      run_host({i[2:0], i[0]});
      chk({6'h00, lat_code_ff}, 8'h03);
      chk(mode_cyc_ff, EXP_MODE[i]);
      chk(lat_cyc_ff, EXP_LAT[i]);
      chk({6'h00, table_ok_ff, op_ok_ff}, 8'h03);
      chk({6'h00, lat_code_c}, 8'h00);
      chk(mode_cyc_c, EXP3_MODE[i]);
      chk(lat_cyc_c, EXP3_LAT[i]);
      chk({6'h00, table_ok_c, op_ok_c}, EXP3_OK[i]);
    end
    stop_test();
  end
endmodule : read_latency_code_table_rom_tb
`default_nettype wire
